// file: logic/wswc_defs.svh
// constants for the watchdog, sleep and wake-up controller
`ifndef WSWC_DEFS_SVH
`define WSWC_DEFS_SVH

`define WSWC_ADDR_STATUS    14'h0003
`define WSWC_ADDR_OPTION    14'h0081
`define WSWC_ADDR_OPTION_HI 14'h0181
`define WSWC_ADDR_CONFIG    14'h2007

`define WSWC_OPTION_RST     8'hFF
`define WSWC_CONFIG_RST     8'h00
`define WSWC_OPT_ASSIGN     3
`define WSWC_OPT_RATIO_MSB  2
`define WSWC_OPT_RATIO_LSB  0
`define WSWC_CFG_WDT_EN     2
`define WSWC_CFG_OSC_MSB    1
`define WSWC_CFG_OSC_LSB    0
`define WSWC_OSC_RC_MODE    2'h3

`define WSWC_ST_TIMEOUT     4
`define WSWC_ST_POWERDOWN   3
`define WSWC_ST_WDT_RESET   0

`define WSWC_ASYNC_SRC_MASK 8'h7F
`define WSWC_IRQ_VECTOR     13'h0004
`define WSWC_WDT_TICKS_DEF  16'h0100

`define WSWC_CLK_NS         100
`define WSWC_TOSC_NS        100
`define WSWC_OST_TOSC       1024
`define WSWC_OST_CYCLES     ((`WSWC_OST_TOSC * `WSWC_TOSC_NS) / `WSWC_CLK_NS)

`endif

// file: logic/wswc_pkg.sv
// types for the watchdog, sleep and wake-up controller
`default_nettype none
package wswc_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OSC_WAIT, ST_RESUME} wswc_state_e;
    typedef logic [7:0] wswc_byte_t;
endpackage
`default_nettype wire

// file: logic/wswc_top.sv
// watchdog timer with sleep entry and wake-up sequencing
// Summary of operation
// - watchdog counts ticks of its own free-running oscillator, also during sleep
// - expiry while running gives a full device reset, recorded as watchdog reset
// - expiry while asleep wakes the device and resumes execution
// - any watchdog expiry clears the time-out flag
// - watchdog stays off while the enable fuse is clear
// - one divider serves the timer as prescaler or the watchdog as postscaler
// - clear-watchdog or sleep zero the counter, and the divider when assigned
// - clear-watchdog zeroes only the divider count, assignment bit untouched
// - sleep clears watchdog, clears power-down, sets time-out, stops oscillator
// - pins keep their drive state while asleep
// - master-clear resets; watchdog or enabled interrupt wake from sleep
// - power-down flag set at power-up, cleared by sleep
// - only clockless peripheral sources can wake from sleep
// - a source wakes only when individually enabled, regardless of global enable
// - prefetched instruction runs on wake, then vector if global enable set
// - sleep with an enabled flag of sources 0 to 6 already pending acts as a no-op
// - flag arriving during sleep lets sleep finish fully, then wakes at once
// - crystal modes wait 1024 oscillator periods on wake; RC mode does not
// - interrupt service clears global enable, loads vector
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wswc_defs.svh"

module wswc_top #(
    parameter logic [15:0] WDT_TICKS = `WSWC_WDT_TICKS_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [13:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  config_fuse_in,
    input  wire logic        wdt_osc_in,
    input  wire logic        master_clear_pin_n,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        sleep_instr,
    input  wire logic [7:0]  irq_flags,
    input  wire logic [7:0]  irq_enables,
    input  wire logic        global_irq_enable,
    input  wire logic        timer_clk_tick,
    input  wire logic [7:0]  io_out_core,
    input  wire logic [7:0]  io_oe_core,
    output logic             device_reset_out,
    output logic             wdt_reset_flag,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n,
    output logic             osc_driver_en,
    output logic             core_run,
    output logic             resume_pulse,
    output logic             asleep,
    output logic             irq_service,
    output logic      [12:0] irq_vector,
    output logic             timer_prescale_tick,
    output logic      [7:0]  io_out,
    output logic      [7:0]  io_oe
);

    // last count of the shared divider for a ratio field and assignment
    function automatic logic [7:0] wswc_div_last(input logic [2:0] ratio, input logic to_wdt);
        logic [8:0] span;
        span = to_wdt ? (9'h001 << ratio) : (9'h002 << ratio);
        return 8'(span - 9'h001);
    endfunction

    wswc_pkg::wswc_state_e state_r;
    wswc_pkg::wswc_state_e state_nxt;
    wswc_pkg::wswc_byte_t  option_r;
    wswc_pkg::wswc_byte_t  config_r;
    logic        cfg_valid_r;
    logic [2:0]  osc_sync_r;
    logic [1:0]  master_clear_pin_sync_r;
    logic [15:0] base_r;
    logic [15:0] base_nxt;
    logic [7:0]  div_r;
    logic [7:0]  div_nxt;
    logic [9:0]  ost_r;
    logic [9:0]  ost_nxt;

    // decode
    wire        osc_tick     = osc_sync_r[1] & ~osc_sync_r[2];
    wire        master_clear_pin_act     = ~master_clear_pin_sync_r[1];
    wire        wdt_en       = cfg_valid_r & config_r[`WSWC_CFG_WDT_EN];
    wire        rc_mode      = config_r[`WSWC_CFG_OSC_MSB:`WSWC_CFG_OSC_LSB] == `WSWC_OSC_RC_MODE;
    wire        div_to_wdt   = option_r[`WSWC_OPT_ASSIGN];
    wire [2:0]  div_ratio    = option_r[`WSWC_OPT_RATIO_MSB:`WSWC_OPT_RATIO_LSB];
    wire [7:0]  div_last     = wswc_div_last(div_ratio, div_to_wdt);
    wire [7:0]  irq_active   = irq_flags & irq_enables;
    wire        pend_any     = |irq_active;
    wire        pend_wake    = |(irq_active & `WSWC_ASYNC_SRC_MASK);
    wire        in_run       = state_r == wswc_pkg::ST_RUN;
    wire        in_sleep     = state_r == wswc_pkg::ST_SLEEP;
    wire        sleep_go     = sleep_instr & in_run & cfg_valid_r & ~pend_wake & ~master_clear_pin_act;
    wire        wdt_clr      = clear_watchdog_instr | sleep_go;
    wire        base_wrap    = wdt_en & ~wdt_clr & osc_tick & (base_r == WDT_TICKS - 16'h0001);
    wire        div_step     = div_to_wdt ? base_wrap : timer_clk_tick;
    wire        div_wrap     = div_step & (div_r == div_last);
    wire        expire       = div_to_wdt ? div_wrap : base_wrap;
    wire        wake_event   = in_sleep & (expire | pend_wake);
    wire        ost_done     = ost_r == 10'(`WSWC_OST_CYCLES - 1);
    wire        serve_now    = in_run & global_irq_enable & pend_any & ~irq_service & ~master_clear_pin_act;

    wire        sel_status   = reg_addr == `WSWC_ADDR_STATUS;
    wire        sel_option   = (reg_addr == `WSWC_ADDR_OPTION) | (reg_addr == `WSWC_ADDR_OPTION_HI);
    wire        sel_config   = reg_addr == `WSWC_ADDR_CONFIG;
    wire        wdt_rst_clr  = reg_wr & sel_status & reg_wdata[`WSWC_ST_WDT_RESET];
    wire [7:0]  status_view  = {3'h0, timeout_flag_n, powerdown_flag_n, 2'h0, wdt_reset_flag};
    wire [7:0]  rd_mux       = sel_status ? status_view :
                               sel_option ? option_r :
                               sel_config ? config_r : 8'h00;

    // watchdog base counter and shared divider
    always_comb
    begin
        base_nxt = base_r;
        if (!wdt_en || wdt_clr)
            base_nxt = 16'h0000;
        else if (osc_tick)
            base_nxt = base_wrap ? 16'h0000 : base_r + 16'h0001;
    end

    always_comb
    begin
        div_nxt = div_r;
        if (div_to_wdt && (wdt_clr || !wdt_en))
            div_nxt = 8'h00; // count only, assignment bit stays
        else if (div_step)
            div_nxt = div_wrap ? 8'h00 : div_r + 8'h01;
    end

    // sleep and wake sequencing
    always_comb
    begin
        state_nxt = state_r;
        ost_nxt = 10'h000;
        case (state_r)
            wswc_pkg::ST_RUN:
            begin
                if (sleep_go)
                    state_nxt = wswc_pkg::ST_SLEEP;
            end
            wswc_pkg::ST_SLEEP:
            begin
                // a flag already up after entry still wakes on the next edge
                if (wake_event)
                    state_nxt = rc_mode ? wswc_pkg::ST_RESUME : wswc_pkg::ST_OSC_WAIT;
            end
            wswc_pkg::ST_OSC_WAIT:
            begin
                ost_nxt = ost_r + 10'h001;
                if (ost_done)
                    state_nxt = wswc_pkg::ST_RESUME;
            end
            wswc_pkg::ST_RESUME:
                state_nxt = wswc_pkg::ST_RUN;
            default:
                state_nxt = wswc_pkg::ST_RUN;
        endcase
        if (master_clear_pin_act)
            state_nxt = wswc_pkg::ST_RUN;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_sync_r  <= 3'h0;
            master_clear_pin_sync_r <= 2'h3;
            cfg_valid_r <= 1'b0;
            config_r    <= `WSWC_CONFIG_RST;
        end
        else
        begin
            osc_sync_r  <= {osc_sync_r[1:0], wdt_osc_in};
            master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_pin_n};
            cfg_valid_r <= 1'b1;
            if (!cfg_valid_r)
                config_r <= config_fuse_in; // fuse frozen after release
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= wswc_pkg::ST_RUN;
            base_r  <= 16'h0000;
            div_r   <= 8'h00;
            ost_r   <= 10'h000;
        end
        else
        begin
            state_r <= state_nxt;
            base_r  <= base_nxt;
            div_r   <= div_nxt;
            ost_r   <= ost_nxt;
        end
    end

    // flags: expiry or sleep entry wins over the opposite update in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
            wdt_reset_flag   <= 1'b0;
        end
        else
        begin
            if (expire && !master_clear_pin_act)
                timeout_flag_n <= 1'b0;
            else if (wdt_clr)
                timeout_flag_n <= 1'b1;
            if (sleep_go)
                powerdown_flag_n <= 1'b0;
            else if (clear_watchdog_instr)
                powerdown_flag_n <= 1'b1;
            if (in_run && expire && !master_clear_pin_act)
                wdt_reset_flag <= 1'b1;
            else if (wdt_rst_clr)
                wdt_reset_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            device_reset_out <= 1'b0;
            osc_driver_en    <= 1'b1;
            core_run         <= 1'b1;
            resume_pulse     <= 1'b0;
            asleep           <= 1'b0;
            irq_service      <= 1'b0;
            irq_vector       <= `WSWC_IRQ_VECTOR;
        end
        else
        begin
            device_reset_out <= master_clear_pin_act | (in_run & expire);
            osc_driver_en    <= state_nxt != wswc_pkg::ST_SLEEP;
            core_run         <= state_nxt == wswc_pkg::ST_RUN;
            resume_pulse     <= (state_r == wswc_pkg::ST_RESUME) & ~master_clear_pin_act;
            asleep           <= state_nxt == wswc_pkg::ST_SLEEP;
            irq_service      <= serve_now;
            irq_vector       <= `WSWC_IRQ_VECTOR;
        end
    end

    // pins follow the core only while running, otherwise hold last drive
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_out <= 8'h00;
            io_oe  <= 8'h00;
        end
        else if (state_nxt == wswc_pkg::ST_RUN && in_run)
        begin
            io_out <= io_out_core;
            io_oe  <= io_oe_core;
        end
    end

    // register port
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            option_r            <= `WSWC_OPTION_RST;
            reg_rdata           <= 8'h00;
            timer_prescale_tick <= 1'b0;
        end
        else
        begin
            if (reg_wr && sel_option)
                option_r <= reg_wdata;
            reg_rdata           <= reg_rd ? rd_mux : 8'h00;
            timer_prescale_tick <= ~div_to_wdt & div_wrap;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_run_expire;
        in_run && expire && !master_clear_pin_act |=> device_reset_out && wdt_reset_flag && !timeout_flag_n;
    endproperty
    a_run_expire: assert property (p_run_expire) else $error("run expiry gave no reset");

    property p_sleep_expire;
        in_sleep && expire && !master_clear_pin_act |=> !device_reset_out && !in_sleep;
    endproperty
    a_sleep_expire: assert property (p_sleep_expire) else $error("sleep expiry no wake");

    property p_expire_to;
        expire && !master_clear_pin_act |=> !timeout_flag_n;
    endproperty
    a_expire_to: assert property (p_expire_to) else $error("time-out flag not cleared");

    property p_fuse_off;
        !wdt_en |-> !expire && base_r == 16'h0000;
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog counted");

    property p_clear;
        clear_watchdog_instr && div_to_wdt && !(reg_wr && sel_option)
            |=> base_r == 16'h0000 && div_r == 8'h00 && $stable(option_r);
    endproperty
    a_clear: assert property (p_clear) else $error("clear left counts");

    property p_sleep_entry;
        sleep_go |=> !powerdown_flag_n && timeout_flag_n && !osc_driver_en && asleep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep effects missing");

    property p_io_hold;
        !in_run && !$past(in_run) |-> $stable(io_out) && $stable(io_oe);
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("pins moved while asleep");

    property p_sleep_nop;
        // a same-cycle expiry legally drops the time-out flag, so it is left to a_expire_to
        sleep_instr && pend_wake && in_run && !clear_watchdog_instr && !expire
            |=> in_run && $stable(powerdown_flag_n) && $stable(timeout_flag_n);
    endproperty
    a_sleep_nop: assert property (p_sleep_nop) else $error("sleep was not a no-op");

    property p_ost_hold;
        state_r == wswc_pkg::ST_OSC_WAIT && !ost_done && !master_clear_pin_act
            |=> state_r == wswc_pkg::ST_OSC_WAIT && ost_r == $past(ost_r) + 10'h001;
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("start-up wait cut short");

    property p_rc_skip;
        wake_event && rc_mode && !master_clear_pin_act |=> state_r == wswc_pkg::ST_RESUME ##1 resume_pulse;
    endproperty
    a_rc_skip: assert property (p_rc_skip) else $error("rc wake slow");

    property p_service;
        irq_service |-> irq_vector == `WSWC_IRQ_VECTOR && $past(global_irq_enable) && core_run;
    endproperty
    a_service: assert property (p_service) else $error("bad interrupt service");

    c_wdt_reset: cover property (in_run && expire);
    c_wdt_wake: cover property (in_sleep && expire);
    c_irq_wake_ost: cover property (state_r == wswc_pkg::ST_OSC_WAIT && ost_done);
    c_sleep_nop: cover property (sleep_instr && pend_wake && in_run);

endmodule
`default_nettype wire

// file: verif/wswc_core_model.sv
// processor core stand-in: issues sleep and clear-watchdog, owns the global enable
`timescale 1ns/1ps
`default_nettype none
module wswc_core_model (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] cmd,
    input  wire logic       core_run,
    input  wire logic       irq_service,
    input  wire logic       device_reset_out,
    output logic            sleep_instr,
    output logic            clear_watchdog_instr,
    output logic            global_irq_enable
);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sleep_instr          <= 1'b0;
            clear_watchdog_instr <= 1'b0;
            global_irq_enable    <= 1'b0;
        end
        else
        begin
            // a stalled core drops sleep and clear-watchdog commands outside run; the enable command is not gated
            sleep_instr          <= cmd[0] & core_run;
            clear_watchdog_instr <= cmd[1] & core_run;
            // drop the enable at once, or service would repeat every other cycle
            if (irq_service | device_reset_out)
                global_irq_enable <= 1'b0;
            else if (cmd[2])
                global_irq_enable <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_watchdog_sleep_wake_control.sv
// self-checking bench for the watchdog, sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_sleep_wake_control;
    typedef struct packed {logic w; logic [13:0] a; logic [7:0] d; logic [7:0] e;} wswc_row_s;
    logic        sys_clk, reset_n, reg_wr, reg_rd, wdt_osc_in, master_clear_pin_n, osc_run;
    logic        clear_watchdog_instr, sleep_instr, global_irq_enable, timer_clk_tick;
    logic        device_reset_out, wdt_reset_flag, timeout_flag_n, powerdown_flag_n;
    logic        osc_driver_en, core_run, resume_pulse, asleep, irq_service, timer_prescale_tick;
    logic [2:0]  cmd, osc_div;
    logic [13:0] reg_addr;
    logic [12:0] irq_vector;
    logic [7:0]  reg_wdata, reg_rdata, config_fuse_in, irq_flags, irq_enables, rd_v;
    logic [7:0]  io_out_core, io_oe_core, io_out, io_oe;
    int          err_count, checked, rst_cnt, ptick, svc_cnt, n;
    wire logic [2:0] evt = {resume_pulse, osc_driver_en, device_reset_out};
    wswc_row_s   rows [8] = '{'{1'b0, 14'h0081, 8'h00, 8'hFF}, '{1'b0, 14'h0003, 8'h00, 8'h18},
        '{1'b0, 14'h2007, 8'h00, 8'h04}, '{1'b1, 14'h2007, 8'hFB, 8'h04},
        '{1'b1, 14'h0003, 8'hFE, 8'h18}, '{1'b1, 14'h0181, 8'h08, 8'h08},
        '{1'b1, 14'h0081, 8'h00, 8'h00}, '{1'b0, 14'h0055, 8'h00, 8'h00}};

    wswc_top #(.WDT_TICKS(16'h0004)) dut_u (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .config_fuse_in, .wdt_osc_in, .master_clear_pin_n,
        .clear_watchdog_instr, .sleep_instr, .irq_flags, .irq_enables, .global_irq_enable,
        .timer_clk_tick, .io_out_core, .io_oe_core, .device_reset_out, .wdt_reset_flag,
        .timeout_flag_n, .powerdown_flag_n, .osc_driver_en, .core_run, .resume_pulse, .asleep,
        .irq_service, .irq_vector, .timer_prescale_tick, .io_out, .io_oe);
    wswc_core_model core_u (.sys_clk, .reset_n, .cmd, .core_run, .irq_service,
        .device_reset_out, .sleep_instr, .clear_watchdog_instr, .global_irq_enable);

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // watchdog oscillator: period 8 clocks, stands still while stopped
    always @(posedge sys_clk)
    begin
        osc_div <= osc_run ? osc_div + 3'h1 : 3'h0;
        if (osc_run && osc_div[1:0] == 2'h3)
            wdt_osc_in <= ~wdt_osc_in;
        if (device_reset_out === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (irq_service === 1'b1)
            svc_cnt <= svc_cnt + 1;
        if (timer_prescale_tick === 1'b1)
            ptick <= ptick + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [13:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [2:0] c);
        cmd <= c;
        @(posedge sys_clk);
        cmd <= 3'h0;
        @(posedge sys_clk);
    endtask
    // a bounded wait on one completion signal, counting edges into n
    task automatic wait_for(input int w, input int lim);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (evt[w] !== 1'b1 && n < lim);
        chk(16'(n < lim), 16'h1);
    endtask
    task automatic tdone(input string s);
        $display("test %0s done", s);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // the whole run needs about 3000 clocks
    initial
    begin
        #1_000_000;
        err_count++;
        conclude();
    end

    initial
    begin
        {reset_n, reg_wr, reg_rd, wdt_osc_in, osc_run, timer_clk_tick, cmd, osc_div} = '0;
        {reg_addr, reg_wdata, irq_flags, irq_enables, io_out_core, io_oe_core} = '0;
        {err_count, checked, rst_cnt, ptick, svc_cnt, n} = '0;
        master_clear_pin_n = 1'b1;
        config_fuse_in = 8'h04;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(2);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk({8'h00, rd_v}, {8'h00, rows[i].e});
        end
        tdone("registers");
        for (int k = 0; k < 2; k++)
        begin
            wr(14'h0081, k ? 8'h00 : 8'h08);
            ptick = 0;
            repeat (8)
            begin
                timer_clk_tick <= 1'b1;
                @(posedge sys_clk);
                timer_clk_tick <= 1'b0;
                @(posedge sys_clk);
            end
            cyc(2);
            chk(16'(ptick), k ? 16'h4 : 16'h0);
        end
        tdone("divider");
        osc_run <= 1'b1;
        wait_for(0, 100);
        osc_run <= 1'b0;
        chk(16'(n >= 28 && n <= 36), 16'h1);
        chk(16'({wdt_reset_flag, timeout_flag_n}), 16'h2);
        rd(14'h0003);
        chk(16'(rd_v), 16'h09);
        wr(14'h0003, 8'h01);
        rd(14'h0003);
        chk(16'(rd_v), 16'h08);
        tdone("run expiry");
        // clear every five ticks: one base wrap each time, so only a divider clear saves it
        wr(14'h0081, 8'h09);
        pulse(3'h2);
        osc_run <= 1'b1;
        rst_cnt = 0;
        repeat (8)
        begin
            pulse(3'h2);
            cyc(38);
        end
        chk(16'(rst_cnt), 16'h0);
        wait_for(0, 200);
        osc_run <= 1'b0;
        rd(14'h0081);
        chk(16'(rd_v), 16'h09);
        tdone("clear watchdog");
        wr(14'h0081, 8'h08);
        io_out_core <= 8'hA5;
        io_oe_core <= 8'h0F;
        cyc(2);
        rst_cnt = 0;
        pulse(3'h1);
        cyc(3);
        chk(16'({asleep, osc_driver_en, core_run}), 16'h4);
        chk(16'({powerdown_flag_n, timeout_flag_n}), 16'h1);
        io_out_core <= 8'h5A;
        io_oe_core <= 8'hF0;
        cyc(3);
        chk({io_out, io_oe}, 16'hA50F);
        osc_run <= 1'b1;
        wait_for(1, 100);
        osc_run <= 1'b0;
        chk(16'({timeout_flag_n, asleep, powerdown_flag_n}), 16'h0);
        wait_for(2, 1100);
        chk(16'(n >= 1024 && n <= 1030), 16'h1);
        chk(16'(rst_cnt), 16'h0);
        cyc(2);
        chk({io_out, io_oe}, 16'h5AF0);
        tdone("watchdog wake");
        irq_enables <= 8'h01;
        pulse(3'h4);
        pulse(3'h1);
        irq_flags <= 8'h02;
        cyc(10);
        chk(16'(asleep), 16'h1);
        irq_flags <= 8'h03;
        svc_cnt = 0;
        wait_for(2, 1100);
        cyc(3);
        chk(16'(svc_cnt), 16'h1);
        chk(16'(irq_vector), 16'h0004);
        chk(16'({timeout_flag_n, powerdown_flag_n}), 16'h2);
        irq_flags <= 8'h02;
        irq_enables <= 8'h02;
        pulse(3'h2);
        pulse(3'h1);
        cyc(3);
        chk(16'({asleep, powerdown_flag_n, timeout_flag_n}), 16'h3);
        tdone("interrupt wake");
        irq_flags <= 8'h80;
        irq_enables <= 8'h80;
        pulse(3'h1);
        cyc(20);
        chk(16'(asleep), 16'h1);
        master_clear_pin_n <= 1'b0;
        cyc(4);
        chk(16'({device_reset_out, core_run, asleep}), 16'h6);
        master_clear_pin_n <= 1'b1;
        irq_flags <= 8'h00;
        cyc(4);
        tdone("master clear");
        // second power-up: watchdog fused off, resistor-capacitor oscillator
        reset_n <= 1'b0;
        config_fuse_in <= 8'h03;
        cyc(12);
        reset_n <= 1'b1;
        cyc(2);
        wr(14'h0081, 8'h08);
        osc_run <= 1'b1;
        rst_cnt = 0;
        cyc(300);
        osc_run <= 1'b0;
        chk({15'(rst_cnt), timeout_flag_n}, 16'h1);
        irq_enables <= 8'h04;
        pulse(3'h1);
        cyc(3);
        chk(16'(asleep), 16'h1);
        svc_cnt = 0;
        irq_flags <= 8'h04;
        wait_for(2, 10);
        chk(16'(n <= 4), 16'h1);
        cyc(3);
        chk(16'(svc_cnt), 16'h0);
        tdone("rc wake");
        conclude();
    end
endmodule
`default_nettype wire
